// ===== ssd_map.vh
// Register map, field positions and timing counts of the stall detector
`ifndef SSD_MAP_VH
`define SSD_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SSD_CTRL_OFS   8'h00
`define SSD_FLAG_OFS   8'h04
`define SSD_COUNT_OFS  8'h08
`define SSD_ACCUM_OFS  8'h0C
`define SSD_STAT_OFS   8'h10
// ****************************************************************
// Control and flag field positions
// ****************************************************************
`define SSD_CTL_STEP_LO   0
`define SSD_CTL_DRV_COIL  2
`define SSD_CTL_INTEG     3
`define SSD_CTL_RECIRC    4
`define SSD_CTL_MSEL      5
`define SSD_CTL_RATE_LO   6
`define SSD_CTL_WAIT_SD   8
`define SSD_CTL_PWR_UP    9
`define SSD_CTL_SEEK_EN   10
`define SSD_CTL_MODMC     11
`define SSD_CTL_PRE512    12
`define SSD_CTL_WIDTH     13
`define SSD_CTL_RESET     13'h0000
`define SSD_FLG_UNDER     7
`define SSD_FLG_OVF       0
// ****************************************************************
// Timing and accumulator values
// ****************************************************************
`define SSD_RATE_BASE     8
`define SSD_MC_DIV_LO     10'h03F
`define SSD_MC_DIV_HI     10'h1FF
`define SSD_ACC_MAX       16'h7FFF
`define SSD_ACC_MIN       16'h8000
`endif

// ===== ssd_accum.v
// Sigma-delta sample accumulator with saturation
`timescale 1ns/1ns
module ssd_accum (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Control
  input  wire        clear,
  input  wire        run,
  input  wire [1:0]  rate_sel,
  input  wire        sample,
  // Result
  output reg  [15:0] acc,
  output reg         ovf_pulse
);
`include "ssd_map.vh"
  reg  [8:0] pre;
  wire [8:0] pre_top;
  wire       tick;
  // Prescale: 8 * 2^rate - 1
  assign pre_top = (9'd`SSD_RATE_BASE << rate_sel) - 9'd1;
  assign tick    = (pre == pre_top);
  // Prescaler restarts whenever integration is off
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= 9'h000;
    end else if (clear || !run || tick) begin
      pre <= 9'h000;
    end else begin
      pre <= pre + 9'd1;
    end
  end
  // Count up or down per sample, saturate at the limits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc       <= 16'h0000;
      ovf_pulse <= 1'b0;
    end else begin
      ovf_pulse <= 1'b0;
      if (clear) begin
        acc <= 16'h0000;
      end else if (run && tick) begin
        if (sample) begin
          if (acc == `SSD_ACC_MAX) begin
            ovf_pulse <= 1'b1;
          end else begin
            acc <= acc + 16'h0001;
          end
        end else begin
          if (acc == `SSD_ACC_MIN) begin
            ovf_pulse <= 1'b1;
          end else begin
            acc <= acc - 16'h0001;
          end
        end
      end
    end
  end
endmodule

// ===== ssd_modcnt.v
// Modulus down-counter with prescaler and load register
`timescale 1ns/1ns
module ssd_modcnt (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Control
  input  wire        halt,
  input  wire        modulus,
  input  wire        pre512,
  input  wire        load_we,
  input  wire [15:0] load_val,
  // Status
  output reg  [15:0] count,
  output reg         zero_pulse
);
`include "ssd_map.vh"
  reg  [9:0]  pre;
  reg  [15:0] load;
  wire [9:0]  pre_top;
  wire        tick;
  assign pre_top = pre512 ? `SSD_MC_DIV_HI : `SSD_MC_DIV_LO;
  assign tick    = (pre >= pre_top);
  // Prescaler frozen while halted
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= 10'h000;
    end else if (!halt) begin
      pre <= tick ? 10'h000 : pre + 10'd1;
    end
  end
  // Down-count, reload in modulus mode, stop at zero otherwise
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count      <= 16'h0000;
      load       <= 16'h0000;
      zero_pulse <= 1'b0;
    end else begin
      zero_pulse <= 1'b0;
      if (load_we) begin
        load <= load_val;
        if (!modulus) begin
          count <= load_val;
        end
      end else if (!halt && tick && count != 16'h0000) begin
        if (count == 16'h0001) begin
          zero_pulse <= 1'b1;
          count      <= modulus ? load : 16'h0000;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end
endmodule

// ===== ssd_stall_detect.v
// Stall detector top: AHB-Lite registers, mode decode, coil drive
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module ssd_stall_detect (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Low-power mode indications
  input  wire        stop_mode,
  input  wire        wait_mode,
  // Converter bitstream
  input  wire        sd_sample,
  // Converter control
  output reg         sd_power_up,
  output reg         sd_reset,
  output reg         offset_comp,
  output reg         sense_cos,
  output reg         motor_select,
  // Sine bridge: drive enable, polarity, recirculate
  output reg         sin_drive,
  output reg         sin_pol,
  output reg         sin_recirc,
  // Cosine bridge
  output reg         cos_drive,
  output reg         cos_pol,
  output reg         cos_recirc
);
`include "ssd_map.vh"
  // ****************************************************************
  // Mode codes
  // ****************************************************************
  localparam MODE_BLANK_OFF = 2'b00;
  localparam MODE_BLANK_ON  = 2'b01;
  localparam MODE_CONVERT   = 2'b10;
  localparam MODE_INTEG     = 2'b11;

  // ****************************************************************
  // Bus address phase capture
  // ****************************************************************
  reg  [`SSD_CTL_WIDTH-1:0] ctrl;
  reg                       under_flag;
  reg                       ovf_flag;
  reg                       wr_pend;
  reg  [7:0]                wr_addr;
  wire                      acc_phase;
  wire                      rd_req;
  wire [15:0]               acc;
  wire [15:0]               count;
  wire                      ovf_pulse;
  wire                      zero_pulse;
  wire                      cnt_we;
  wire [1:0]                mode;
  wire [1:0]                step;
  wire                      seek_en;
  wire                      lp_halt;
  wire                      blanking;
  reg  [31:0]               next_rdata;
  reg                       flag_w1c_u;
  reg                       flag_w1c_o;
  wire                      acc_run;
  wire [1:0]                rate_sel;
  wire                      comp_win;

  assign acc_phase = hsel && hready && htrans[1];
  assign rd_req    = acc_phase && !hwrite;

  // Write address held until data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc_phase && hwrite;
      if (acc_phase) begin
        wr_addr <= haddr;
      end
    end
  end

  // Single-cycle response, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Control register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `SSD_CTL_RESET;
    end else if (wr_pend && wr_addr == `SSD_CTRL_OFS) begin
      ctrl <= hwdata[`SSD_CTL_WIDTH-1:0];
    end
  end

  // Write-one-to-clear requests
  always @* begin
    flag_w1c_u = wr_pend && wr_addr == `SSD_FLAG_OFS
                 && hwdata[`SSD_FLG_UNDER];
    flag_w1c_o = wr_pend && wr_addr == `SSD_FLAG_OFS
                 && hwdata[`SSD_FLG_OVF];
  end

  // Sticky flags, set wins over clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      under_flag <= 1'b0;
      ovf_flag   <= 1'b0;
    end else begin
      if (zero_pulse) begin
        under_flag <= 1'b1;
      end else if (flag_w1c_u) begin
        under_flag <= 1'b0;
      end
      if (ovf_pulse) begin
        ovf_flag <= 1'b1;
      end else if (flag_w1c_o) begin
        ovf_flag <= 1'b0;
      end
    end
  end

  assign cnt_we = wr_pend && wr_addr == `SSD_COUNT_OFS;

  // Accumulator runs only while integrating with a live converter
  assign acc_run  = ctrl[`SSD_CTL_INTEG] && !lp_halt && sd_power_up;
  assign rate_sel = ctrl[`SSD_CTL_RATE_LO+1:`SSD_CTL_RATE_LO];

  // ****************************************************************
  // Mode decode and low-power control
  // ****************************************************************
  assign mode     = {ctrl[`SSD_CTL_INTEG], ctrl[`SSD_CTL_DRV_COIL]};
  assign step     = ctrl[`SSD_CTL_STEP_LO+1:`SSD_CTL_STEP_LO];
  assign seek_en  = ctrl[`SSD_CTL_SEEK_EN];
  assign lp_halt  = stop_mode
                    || (wait_mode && ctrl[`SSD_CTL_WAIT_SD]);
  assign blanking = !ctrl[`SSD_CTL_INTEG];
  // Offset compensation window: integrating while the counter runs
  assign comp_win = (mode == MODE_INTEG) && (count != 16'h0000);

  // ****************************************************************
  // Accumulator and counter
  // ****************************************************************
  ssd_accum u_accum (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear     (blanking),
    .run       (acc_run),
    .rate_sel  (rate_sel),
    .sample    (sd_sample),
    .acc       (acc),
    .ovf_pulse (ovf_pulse)
  );

  ssd_modcnt u_modcnt (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .halt       (lp_halt),
    .modulus    (ctrl[`SSD_CTL_MODMC]),
    .pre512     (ctrl[`SSD_CTL_PRE512]),
    .load_we    (cnt_we),
    .load_val   (hwdata[15:0]),
    .count      (count),
    .zero_pulse (zero_pulse)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      `SSD_CTRL_OFS:  next_rdata = {19'h00000, ctrl};
      `SSD_FLAG_OFS:  next_rdata = {24'h000000, under_flag, 6'h00,
                                    ovf_flag};
      `SSD_COUNT_OFS: next_rdata = {16'h0000, count};
      `SSD_ACCUM_OFS: next_rdata = {16'h0000, acc};
      `SSD_STAT_OFS:  next_rdata = {29'h00000000, lp_halt,
                                    sd_power_up, sd_reset};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Converter control outputs
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sd_power_up  <= 1'b0;
      sd_reset     <= 1'b1;
      offset_comp  <= 1'b0;
      motor_select <= 1'b0;
    end else begin
      sd_power_up  <= ctrl[`SSD_CTL_PWR_UP] && !lp_halt;
      sd_reset     <= blanking;
      offset_comp  <= comp_win;
      motor_select <= ctrl[`SSD_CTL_MSEL];
    end
  end

  // ****************************************************************
  // Full-step table
  // ****************************************************************
  localparam STEP_0 = 2'b00;
  localparam STEP_1 = 2'b01;
  localparam STEP_2 = 2'b10;
  localparam STEP_3 = 2'b11;

  reg                       next_sense_cos;
  reg                       next_sin_pol;
  reg                       next_cos_pol;
  reg                       next_sin_drive;
  reg                       next_sin_recirc;
  reg                       next_cos_drive;
  reg                       next_cos_recirc;

  // Sensed coil and bridge polarity for each 90 degree step
  // Even steps sense the sine coil, odd steps the cosine coil
  // Polarities turn a quarter cycle per step, one phase at a time
  always @* begin
    case (step)
      STEP_0: begin
        next_sense_cos = 1'b0;
        next_sin_pol   = 1'b0;
        next_cos_pol   = 1'b0;
      end
      STEP_1: begin
        next_sense_cos = 1'b1;
        next_sin_pol   = 1'b0;
        next_cos_pol   = 1'b1;
      end
      STEP_2: begin
        next_sense_cos = 1'b0;
        next_sin_pol   = 1'b1;
        next_cos_pol   = 1'b1;
      end
      STEP_3: begin
        next_sense_cos = 1'b1;
        next_sin_pol   = 1'b1;
        next_cos_pol   = 1'b0;
      end
      default: begin
        next_sense_cos = 1'b0;
        next_sin_pol   = 1'b0;
        next_cos_pol   = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Coil bridge drive per mode
  // ****************************************************************
  // The sensed coil recirculates or floats and is never driven
  always @* begin
    next_sin_drive  = 1'b0;
    next_sin_recirc = 1'b0;
    next_cos_drive  = 1'b0;
    next_cos_recirc = 1'b0;
    if (!seek_en) begin
      // Seeking off: every bridge switch stays open
      next_sin_drive  = 1'b0;
    end else if (lp_halt && wait_mode) begin
      // Wait shutdown parks both coils in recirculation
      next_sin_recirc = 1'b1;
      next_cos_recirc = 1'b1;
    end else begin
      // Masked coil follows the sensed one; the other may drive
      case (mode)
        MODE_BLANK_OFF: begin
          // Other coil left disconnected
          next_sin_recirc = !next_sense_cos;
          next_cos_recirc = next_sense_cos;
        end
        MODE_BLANK_ON: begin
          next_sin_recirc = !next_sense_cos;
          next_cos_recirc = next_sense_cos;
          next_sin_drive  = next_sense_cos;
          next_cos_drive  = !next_sense_cos;
        end
        MODE_CONVERT: begin
          // Both coils off the drivers
          next_sin_drive = 1'b0;
          next_cos_drive = 1'b0;
        end
        MODE_INTEG: begin
          // Sensed coil integrates, the other one drives
          next_sin_drive = next_sense_cos;
          next_cos_drive = !next_sense_cos;
        end
        default: begin
          next_sin_drive = 1'b0;
          next_cos_drive = 1'b0;
        end
      endcase
    end
  end

  // Bridge and converter routing registered straight to the pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_cos  <= 1'b0;
      sin_drive  <= 1'b0;
      sin_pol    <= 1'b0;
      sin_recirc <= 1'b0;
      cos_drive  <= 1'b0;
      cos_pol    <= 1'b0;
      cos_recirc <= 1'b0;
    end else begin
      sense_cos  <= next_sense_cos;
      sin_drive  <= next_sin_drive;
      sin_pol    <= next_sin_pol;
      sin_recirc <= next_sin_recirc;
      cos_drive  <= next_cos_drive;
      cos_pol    <= next_cos_pol;
      cos_recirc <= next_cos_recirc;
    end
  end
endmodule

// ===== sdc_checker_assertions.sv
// Concurrent checks on the stall detector top ports
`timescale 1ns/1ns
module sdc_checker (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  // Converter and coils
  input wire        stop_mode,
  input wire        sd_power_up,
  input wire        sd_reset,
  input wire        offset_comp,
  input wire        sense_cos,
  input wire        sin_drive,
  input wire        sin_recirc,
  input wire        cos_drive,
  input wire        cos_recirc
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_STOP_PWR_DOWN: assert property (stop_mode [*2] |=> !sd_power_up)
    else $error("converter powered during stop");
  AST_PWR_RISE: assert property ($rose(sd_power_up) |-> !$past(stop_mode))
    else $error("converter powered up while stopped");
  AST_BLANK_NO_COMP: assert property (sd_reset |-> !offset_comp)
    else $error("offset compensation while converter reset");
  AST_SIN_SENSE: assert property (!sense_cos |-> !sin_drive)
    else $error("sensed sine coil is driven");
  AST_COS_SENSE: assert property (sense_cos |-> !cos_drive)
    else $error("sensed cosine coil is driven");
  AST_SIN_EXCL: assert property (sin_drive |-> !sin_recirc)
    else $error("sine bridge drives and recirculates");
  AST_COS_EXCL: assert property (cos_recirc |-> !cos_drive)
    else $error("cosine bridge drives and recirculates");
  AST_HRDATA_HOLD: assert property
    (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  // Main scenarios reached
  cover property (stop_mode ##1 !sd_power_up);
  cover property (sin_recirc && cos_recirc);
  cover property (offset_comp);
endmodule

bind ssd_stall_detect sdc_checker u_sdc_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .stop_mode(stop_mode), .sd_power_up(sd_power_up), .sd_reset(sd_reset),
  .offset_comp(offset_comp), .sense_cos(sense_cos),
  .sin_drive(sin_drive), .sin_recirc(sin_recirc),
  .cos_drive(cos_drive), .cos_recirc(cos_recirc)
);

// ===== sdc_coil_model.sv
// Behavioural motor coils feeding the converter bitstream
`timescale 1ns/1ns
module sdc_coil_model (
  // Clock
  input wire       hclk,
  // Converter control
  input wire       sd_power_up,
  input wire       sd_reset,
  // Bridge states
  input wire       sin_drive,
  input wire       sin_recirc,
  input wire       cos_drive,
  input wire       cos_recirc,
  // Back-EMF sign: 0 none, 1 rising, 2 falling
  input wire [1:0] emf_mode,
  // Converter bit and coil short count
  output reg       sd_sample = 1'b0,
  output reg [7:0] shorts = 8'h00
);
  // Idle converter toggles so no stale level lingers
  always @(posedge hclk) begin
    if (!sd_power_up || sd_reset || emf_mode == 2'h0) begin
      sd_sample <= ~sd_sample;
    end else begin
      sd_sample <= (emf_mode == 2'h1);
    end
    if ((sin_drive && sin_recirc) || (cos_drive && cos_recirc)) begin
      shorts <= shorts + 8'h01;
    end
  end
endmodule

// ===== tb_stepper_stall_detect_control.sv
// Self-checking bench for the stall detector top
`timescale 1ns/1ns
module tb_stepper_stall_detect_control;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [7:0]  haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata;
  reg         stop_mode;
  reg         wait_mode;
  reg  [1:0]  emf_mode;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        sd_sample;
  wire        sd_power_up;
  wire        sd_reset;
  wire        offset_comp;
  wire        sense_cos;
  wire        motor_select;
  wire        sin_drive;
  wire        sin_pol;
  wire        sin_recirc;
  wire        cos_drive;
  wire        cos_pol;
  wire        cos_recirc;
  wire [7:0]  shorts;
  wire [5:0]  coils;
  integer     fails;
  integer     num_checks;
  integer     s;
  integer     m;
  integer     j;
  reg  [31:0] d0;
  reg  [31:0] d1;
  reg  [3:0]  pol;
  reg  [5:0]  ce;
  // ****************************************************************
  // Design, motor and clock
  // ****************************************************************
  assign coils = {sd_reset, sense_cos, sin_drive, sin_recirc,
                  cos_drive, cos_recirc};
  ssd_stall_detect u_ssd_stall_detect (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .sd_sample(sd_sample),
    .sd_power_up(sd_power_up), .sd_reset(sd_reset),
    .offset_comp(offset_comp), .sense_cos(sense_cos),
    .motor_select(motor_select), .sin_drive(sin_drive), .sin_pol(sin_pol),
    .sin_recirc(sin_recirc), .cos_drive(cos_drive), .cos_pol(cos_pol),
    .cos_recirc(cos_recirc));
  sdc_coil_model u_sdc_coil_model (
    .hclk(hclk), .sd_power_up(sd_power_up), .sd_reset(sd_reset),
    .sin_drive(sin_drive), .sin_recirc(sin_recirc), .cos_drive(cos_drive),
    .cos_recirc(cos_recirc), .emf_mode(emf_mode), .sd_sample(sd_sample),
    .shorts(shorts));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Single bus transfer, read data taken at the data-phase edge
  task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge hclk);
      #1;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Watchdog against a hung transfer
  initial begin
    repeat (20000) @(posedge hclk);
    fails = fails + 1;
    tally_and_finish;
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    fails = 0;
    num_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    emf_mode = 2'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(coils), 32'h20);
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF, d0);
    xfer(1'b1, 8'h0C, 32'h0000_1234, d0);
    for (j = 0; j < 6; j = j + 1) begin
      xfer(1'b0, {j[5:0], 2'b00}, 32'h0, d0);
      chk(d0, {31'h0, j == 4});
      chk(32'({hresp, hreadyout}), 32'h1);
    end
    // Second motor select toggled during init
    xfer(1'b1, 8'h00, 32'h20, d0);
    settle;
    chk(32'(motor_select), 32'h1);
    xfer(1'b1, 8'h00, 32'h0, d0);
    settle;
    chk(32'(motor_select), 32'h0);
    // Every step under every mode, steps climbing
    for (s = 0; s < 4; s = s + 1) begin
      for (m = 0; m < 4; m = m + 1) begin
        xfer(1'b1, 8'h00, 32'h400 | (m << 2) | s, d0);
        settle;
        ce = {~m[1], s[0], s[0] & m[0], ~s[0] & ~m[1],
              ~s[0] & m[0], s[0] & ~m[1]};
        chk(32'(coils), 32'(ce));
        if (m == 1) pol[s] = s[0] ? sin_pol : cos_pol;
      end
    end
    chk(32'(pol[3:2]), {30'h0, ~pol[1:0]});
    xfer(1'b1, 8'h00, 32'h4, d0);
    settle;
    chk(32'(coils), 32'h20);
    // Ramps of both signs at every sample rate
    for (j = 0; j < 8; j = j + 1) begin
      emf_mode <= 2'h1 + {1'b0, j[0]};
      xfer(1'b1, 8'h00, 32'h200 | (j[2:1] << 6), d0);
      xfer(1'b1, 8'h00, 32'h208 | (j[2:1] << 6), d0);
      xfer(1'b0, 8'h0C, 32'h0, d0);
      repeat ((64 << j[2:1]) - 3) @(posedge hclk);
      xfer(1'b0, 8'h0C, 32'h0, d1);
      chk({16'h0000, d1[15:0] - d0[15:0]},
          j[0] ? 32'hFFF8 : 32'h8);
    end
    xfer(1'b1, 8'h00, 32'h200, d0);
    xfer(1'b0, 8'h0C, 32'h0, d0);
    chk(d0, 32'h0);
    xfer(1'b0, 8'h04, 32'h0, d0);
    chk(d0, 32'h0);
    // Counter timing an integration window
    xfer(1'b1, 8'h00, 32'h20C, d0);
    xfer(1'b1, 8'h08, 32'hA, d0);
    settle;
    chk(32'(offset_comp), 32'h1);
    xfer(1'b0, 8'h08, 32'h0, d0);
    repeat (125) @(posedge hclk);
    xfer(1'b0, 8'h08, 32'h0, d1);
    chk(d0 - d1, 32'h2);
    repeat (700) @(posedge hclk);
    xfer(1'b0, 8'h04, 32'h0, d0);
    chk(d0, 32'h80);
    chk(32'(offset_comp), 32'h0);
    xfer(1'b1, 8'h04, 32'h80, d0);
    xfer(1'b1, 8'h08, 32'h0, d0);
    repeat (200) @(posedge hclk);
    xfer(1'b0, 8'h04, 32'h0, d0);
    chk(d0, 32'h0);
    // Stop freezes the counter and powers the converter down
    xfer(1'b1, 8'h08, 32'h100, d0);
    stop_mode <= 1'b1;
    settle;
    chk(32'(sd_power_up), 32'h0);
    xfer(1'b0, 8'h10, 32'h0, d0);
    chk(d0, 32'h4);
    xfer(1'b0, 8'h08, 32'h0, d0);
    repeat (200) @(posedge hclk);
    xfer(1'b0, 8'h08, 32'h0, d1);
    chk(d1, d0);
    stop_mode <= 1'b0;
    settle;
    chk(32'(sd_power_up), 32'h1);
    xfer(1'b1, 8'h00, 32'h200, d0);
    // Wait mode with and without shutdown
    @(posedge hclk);
    wait_mode <= 1'b1;
    settle;
    chk(32'(sd_power_up), 32'h1);
    xfer(1'b1, 8'h00, 32'h704, d0);
    settle;
    chk(32'({sd_power_up, coils}), 32'h25);
    @(posedge hclk);
    wait_mode <= 1'b0;
    settle;
    chk(32'({sd_power_up, coils}), 32'h66);
    xfer(1'b1, 8'h00, 32'h0, d0);
    settle;
    chk(32'(sd_power_up), 32'h0);
    chk(32'(shorts), 32'h0);
    tally_and_finish;
  end
endmodule
